// [cfgw_regs.svh]
// Register offsets, field positions, reset values and counts for the
// configuration-3 grant, tuning and wake-pattern block.
// Assumes a 32-bit APB slave with word-aligned byte addresses.
// Contract
// - Select 0 drives FRAME# at once after GNT#; 1 adds one clock.
// - Autoload off and both EEPROM mode bits set lets software write tunings.
// - Autoload on loads from EEPROM and blocks software tuning writes.
// - Only the twister tuning value is ever loaded from the EEPROM.
// - Wake-pattern enable works only while the wake allow bit is set.
// - A qualifying wake frame with detection on pulls the event output low.
// - In wake-pattern mode every frame for this node is scanned.
// - Own node ID or any multicast destination qualifies if copies match.
// - Sequence is sixteen back-to-back copies of the six-byte node ID.
// - The ID copies must directly follow six bytes of FFh.
// - Sync run and copies are found at any byte position.
// - Only a well-formed frame with addresses, data and good CRC qualifies.
`ifndef CFGW_REGS_SVH
`define CFGW_REGS_SVH

`define CFGW_ADDR_W        8
`define CFGW_OFF_CFG3      8'h00
`define CFGW_OFF_CFG1      8'h04
`define CFGW_OFF_EECMD     8'h08
`define CFGW_OFF_PHY1      8'h0c
`define CFGW_OFF_PHY2      8'h10
`define CFGW_OFF_TW        8'h14
`define CFGW_OFF_IDLO      8'h18
`define CFGW_OFF_IDHI      8'h1c
`define CFGW_OFF_ISTAT     8'h20
`define CFGW_OFF_IMASK     8'h24

`define CFGW_CFG3_GRANT_FRAME_DELAY_SEL   7
`define CFGW_CFG3_AUTOLD   6
`define CFGW_CFG3_WAKEPAT  5
`define CFGW_CFG1_WAKEOK   0
`define CFGW_EE_MODE_HI    7
`define CFGW_EE_MODE_LO    6

`define CFGW_IRQ_WAKE      0
`define CFGW_IRQ_TWLOAD    1
`define CFGW_IRQ_W         2

`define CFGW_RST_BYTE      8'h00
`define CFGW_RST_ID32      32'h0000_0000
`define CFGW_RST_ID16      16'h0000
`define CFGW_RST_IRQ       2'h0

`define CFGW_SYNC_BYTE     8'hff
`define CFGW_SYNC_LEN      3'h6
`define CFGW_ID_LAST       3'h5
`define CFGW_COPY_LAST     4'hf

`endif

// [cfgw_pkg.sv]
// Types shared by the configuration-3 wake block.
// Assumes the constants of cfgw_regs.svh.
package cfgw_pkg;

    // Received byte stream from the MAC, one byte per valid cycle
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic       crcOk;
        logic       addrMatch;
        logic [7:0] data;
    } cfgw_rx_t;

    // EEPROM autoload of the twister tuning value
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } cfgw_eeload_t;

    typedef enum logic [1:0] {
        GNT_IDLE = 2'b00,
        GNT_WAIT = 2'b01,
        GNT_OWN  = 2'b10
    } cfgw_gnt_state_t;

endpackage : cfgw_pkg

// [cfgw_top.sv]
// Configuration-3 grant delay, tuning parameter load and wake-pattern detector.
// Assumes an APB master, a MAC supplying received bytes with address filter
// and CRC result, and an EEPROM loader delivering the twister tuning byte.
`timescale 1ns/10ps
`default_nettype none
`include "cfgw_regs.svh"

module cfgw_top (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output var  logic [31:0]             prdata,
    output var  logic                    pready,
    output var  logic                    pslverr,
    // PCI arbitration
    input  wire logic                    gnt_n,
    input  wire logic                    busReq,
    input  wire logic                    gntDelayStrap,
    output var  logic                    frame_n,
    // Receive path and EEPROM loader
    input  wire cfgw_pkg::cfgw_rx_t      rx,
    input  wire cfgw_pkg::cfgw_eeload_t  eeLoad,
    // Tuning values to the PHY and twister
    output var  logic [7:0]              phyTuningOne,
    output var  logic [7:0]              phyTuningTwo,
    output var  logic [7:0]              twisterTuning,
    // Events
    output var  logic                    pm_event_n,
    output var  logic                    irq
);
    import cfgw_pkg::*;

    // Reset synchroniser
    logic rstMeta_q;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rst_n     <= rstMeta_q;
        end
    end

    // Registers
    logic                  grant_frame_delay_sel_q;
    logic                  strapDone_q;
    logic                  autoload_q;
    logic                  wakePatEn_q;
    logic                  wakeAllow_q;
    logic                  eeModeHi_q;
    logic                  eeModeLo_q;
    logic [7:0]            phy1_q;
    logic [7:0]            phy2_q;
    logic [7:0]            tw_q;
    logic [31:0]           idLo_q;
    logic [15:0]           idHi_q;
    logic [`CFGW_IRQ_W-1:0] istat_q;
    logic [`CFGW_IRQ_W-1:0] istat_d;
    logic [`CFGW_IRQ_W-1:0] imask_q;
    logic [`CFGW_IRQ_W-1:0] evt;

    // APB decode
    logic        wrEn;
    logic        setup;
    logic        mapped;
    logic [31:0] rdMux;
    logic        tuneWrOk;

    assign setup = psel & ~penable;
    assign wrEn  = psel & penable & pready & pwrite & ~pslverr;

    always_comb begin
        mapped = 1'b1;
        rdMux  = 32'h0000_0000;
        unique case (paddr)
            `CFGW_OFF_CFG3: begin
                rdMux[`CFGW_CFG3_GRANT_FRAME_DELAY_SEL]  = grant_frame_delay_sel_q;
                rdMux[`CFGW_CFG3_AUTOLD]  = autoload_q;
                rdMux[`CFGW_CFG3_WAKEPAT] = wakePatEn_q;
            end
            `CFGW_OFF_CFG1: begin
                rdMux[`CFGW_CFG1_WAKEOK] = wakeAllow_q;
            end
            `CFGW_OFF_EECMD: begin
                rdMux[`CFGW_EE_MODE_HI] = eeModeHi_q;
                rdMux[`CFGW_EE_MODE_LO] = eeModeLo_q;
            end
            `CFGW_OFF_PHY1:  rdMux[7:0] = phy1_q;
            `CFGW_OFF_PHY2:  rdMux[7:0] = phy2_q;
            `CFGW_OFF_TW:    rdMux[7:0] = tw_q;
            `CFGW_OFF_IDLO:  rdMux = idLo_q;
            `CFGW_OFF_IDHI:  rdMux[15:0] = idHi_q;
            `CFGW_OFF_ISTAT: rdMux[`CFGW_IRQ_W-1:0] = istat_q;
            `CFGW_OFF_IMASK: rdMux[`CFGW_IRQ_W-1:0] = imask_q;
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Answer one cycle after setup; data captured at setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= (setup & ~pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    // Grant select is read-only, caught from a strap after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grant_frame_delay_sel_q    <= 1'b0;
            strapDone_q <= 1'b0;
        end else if (!strapDone_q) begin
            grant_frame_delay_sel_q    <= gntDelayStrap;
            strapDone_q <= 1'b1;
        end
    end

    // Configuration bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            autoload_q  <= 1'b0;
            wakePatEn_q <= 1'b0;
            wakeAllow_q <= 1'b0;
            eeModeHi_q  <= 1'b0;
            eeModeLo_q  <= 1'b0;
            idLo_q      <= `CFGW_RST_ID32;
            idHi_q      <= `CFGW_RST_ID16;
            imask_q     <= `CFGW_RST_IRQ;
        end else if (wrEn) begin
            unique case (paddr)
                `CFGW_OFF_CFG3: begin
                    autoload_q  <= pwdata[`CFGW_CFG3_AUTOLD];
                    wakePatEn_q <= pwdata[`CFGW_CFG3_WAKEPAT];
                end
                `CFGW_OFF_CFG1: begin
                    wakeAllow_q <= pwdata[`CFGW_CFG1_WAKEOK];
                end
                `CFGW_OFF_EECMD: begin
                    eeModeHi_q <= pwdata[`CFGW_EE_MODE_HI];
                    eeModeLo_q <= pwdata[`CFGW_EE_MODE_LO];
                end
                `CFGW_OFF_IDLO:  idLo_q  <= pwdata;
                `CFGW_OFF_IDHI:  idHi_q  <= pwdata[15:0];
                `CFGW_OFF_IMASK: imask_q <= pwdata[`CFGW_IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Tuning registers
    assign tuneWrOk = wrEn & ~autoload_q & eeModeHi_q & eeModeLo_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phy1_q <= `CFGW_RST_BYTE;
            phy2_q <= `CFGW_RST_BYTE;
        end else if (tuneWrOk) begin
            if (paddr == `CFGW_OFF_PHY1) begin
                phy1_q <= pwdata[7:0];
            end
            if (paddr == `CFGW_OFF_PHY2) begin
                phy2_q <= pwdata[7:0];
            end
        end
    end

    // Only the twister value follows the EEPROM loader
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tw_q <= `CFGW_RST_BYTE;
        end else if (autoload_q && eeLoad.valid) begin
            tw_q <= eeLoad.data;
        end else if (tuneWrOk && paddr == `CFGW_OFF_TW) begin
            tw_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phyTuningOne  <= `CFGW_RST_BYTE;
            phyTuningTwo  <= `CFGW_RST_BYTE;
            twisterTuning <= `CFGW_RST_BYTE;
        end else begin
            phyTuningOne  <= phy1_q;
            phyTuningTwo  <= phy2_q;
            twisterTuning <= tw_q;
        end
    end

    // FRAME# after GNT#
    cfgw_gnt_state_t gntState_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gntState_q <= GNT_IDLE;
            frame_n    <= 1'b1;
        end else begin
            unique case (gntState_q)
                GNT_IDLE: begin
                    if (busReq && !gnt_n) begin
                        if (grant_frame_delay_sel_q) begin
                            gntState_q <= GNT_WAIT;
                        end else begin
                            gntState_q <= GNT_OWN;
                            frame_n    <= 1'b0;
                        end
                    end
                end
                GNT_WAIT: begin
                    gntState_q <= GNT_OWN;
                    frame_n    <= 1'b0;
                end
                GNT_OWN: begin
                    if (!busReq) begin
                        gntState_q <= GNT_IDLE;
                        frame_n    <= 1'b1;
                    end
                end
                default: begin
                    gntState_q <= GNT_IDLE;
                    frame_n    <= 1'b1;
                end
            endcase
        end
    end

    // Wake-pattern detector
    logic       armed;
    logic [2:0] syncCnt_q;
    logic       inId_q;
    logic [2:0] idPos_q;
    logic [3:0] copy_q;
    logic       found_q;
    logic [7:0] expByte;
    logic [7:0] id0;
    logic       isSync;
    logic       syncFull;
    logic       wakeHit;

    assign armed    = wakePatEn_q & wakeAllow_q;
    assign id0      = idLo_q[7:0];
    assign isSync   = rx.data == `CFGW_SYNC_BYTE;
    assign syncFull = syncCnt_q == `CFGW_SYNC_LEN;

    always_comb begin
        unique case (idPos_q)
            3'h0:    expByte = idLo_q[7:0];
            3'h1:    expByte = idLo_q[15:8];
            3'h2:    expByte = idLo_q[23:16];
            3'h3:    expByte = idLo_q[31:24];
            3'h4:    expByte = idHi_q[7:0];
            3'h5:    expByte = idHi_q[15:8];
            default: expByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncCnt_q <= 3'h0;
            inId_q    <= 1'b0;
            idPos_q   <= 3'h0;
            copy_q    <= 4'h0;
            found_q   <= 1'b0;
        end else if (rx.valid && (rx.sof || !armed)) begin
            syncCnt_q <= (armed && isSync) ? 3'h1 : 3'h0;
            inId_q    <= 1'b0;
            idPos_q   <= 3'h0;
            copy_q    <= 4'h0;
            found_q   <= 1'b0;
        end else if (rx.valid && !found_q) begin
            if (inId_q) begin
                if (rx.data == expByte) begin
                    if (idPos_q == `CFGW_ID_LAST) begin
                        idPos_q <= 3'h0;
                        copy_q  <= copy_q + 4'h1;
                        if (copy_q == `CFGW_COPY_LAST) begin
                            found_q <= 1'b1;
                            inId_q  <= 1'b0;
                        end
                    end else begin
                        idPos_q <= idPos_q + 3'h1;
                    end
                end else begin
                    inId_q    <= 1'b0;
                    idPos_q   <= 3'h0;
                    copy_q    <= 4'h0;
                    syncCnt_q <= isSync ? 3'h1 : 3'h0;
                end
            end else if (syncFull && rx.data == id0 && !isSync) begin
                inId_q    <= 1'b1;
                idPos_q   <= 3'h1;
                syncCnt_q <= 3'h0;
            end else if (isSync) begin
                if (!syncFull) begin
                    syncCnt_q <= syncCnt_q + 3'h1;
                end
            end else begin
                syncCnt_q <= 3'h0;
            end
        end
    end

    // Qualify at end of frame: addresses, CRC and the full sequence
    assign wakeHit = rx.valid & rx.eof & armed & found_q
                   & rx.crcOk & rx.addrMatch;

    // Sticky status, set wins over write-one clear
    always_comb begin
        evt = '0;
        evt[`CFGW_IRQ_WAKE]   = wakeHit;
        evt[`CFGW_IRQ_TWLOAD] = autoload_q & eeLoad.valid;
        istat_d = istat_q;
        if (wrEn && paddr == `CFGW_OFF_ISTAT) begin
            istat_d = istat_q & ~pwdata[`CFGW_IRQ_W-1:0];
        end
        istat_d = istat_d | evt;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            istat_q <= `CFGW_RST_IRQ;
        end else begin
            istat_q <= istat_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq        <= 1'b0;
            pm_event_n <= 1'b1;
        end else begin
            irq        <= |(istat_d & imask_q);
            pm_event_n <= ~istat_d[`CFGW_IRQ_WAKE];
        end
    end

endmodule : cfgw_top

`default_nettype wire

// [cfgw_pci_arbiter.sv]
// PCI arbiter model on the far side of the grant input.
// Assumes one clock; the grant line idles high when not granted.
`timescale 1ns/10ps
`default_nettype none

module cfgw_pci_arbiter (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Arbitration
    input  wire logic       busReq,
    input  wire logic [1:0] grantLag,
    output var  logic       gnt_n
);
    logic [1:0] waitCnt_q;

    // Grants grantLag+1 cycles after the request, withdraws when it drops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gnt_n     <= 1'b1;
            waitCnt_q <= 2'h0;
        end else if (!busReq) begin
            gnt_n     <= 1'b1;
            waitCnt_q <= 2'h0;
        end else if (waitCnt_q == grantLag) begin
            gnt_n <= 1'b0;
        end else begin
            waitCnt_q <= waitCnt_q + 2'h1;
        end
    end
endmodule : cfgw_pci_arbiter

`default_nettype wire

// [cfgw_top_assertions.sv]
// Port checks for cfgw_top: APB timing, grant delay, wake event, tuning sources.
// Assumes the strap input changes only while arst_n is low.
`timescale 1ns/10ps
`default_nettype none
`include "cfgw_regs.svh"

module cfgw_top_assertions (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   arst_n,
    // APB
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    // Grant
    input wire logic                   gnt_n,
    input wire logic                   busReq,
    input wire logic                   gntDelayStrap,
    input wire logic                   frame_n,
    // Receive, load and outputs
    input wire cfgw_pkg::cfgw_rx_t     rx,
    input wire cfgw_pkg::cfgw_eeload_t eeLoad,
    input wire logic [7:0]             phyTuningOne,
    input wire logic [7:0]             twisterTuning,
    input wire logic                   pm_event_n
);
    import cfgw_pkg::*;
    logic goodEnd;
    logic clrWr;
    logic twSet;
    logic phySet;
    assign goodEnd = rx.valid && rx.eof && rx.crcOk && rx.addrMatch;
    assign clrWr = psel && penable && pwrite && paddr == `CFGW_OFF_ISTAT && pwdata[0];
    assign twSet = eeLoad.valid || (psel && penable && pwrite && paddr == `CFGW_OFF_TW);
    assign phySet = psel && penable && pwrite && paddr == `CFGW_OFF_PHY1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside access");
    a_frame_no_delay: assert property ($fell(frame_n) && !gntDelayStrap |-> $past(!gnt_n && busReq))
        else $error("frame not at grant edge");
    a_frame_one_late: assert property ($fell(frame_n) && gntDelayStrap |-> $past(!gnt_n && busReq, 2))
        else $error("frame not one clock after grant");
    a_frame_release: assert property (!frame_n && !busReq |=> frame_n)
        else $error("frame kept after request dropped");
    a_wake_cause: assert property ($fell(pm_event_n) |-> $past(goodEnd) || $past(goodEnd, 2))
        else $error("wake event without good frame end");
    a_wake_clear: assert property ($rose(pm_event_n) |-> $past(clrWr) || $past(clrWr, 2))
        else $error("wake event ended without clear");
    a_tw_source: assert property ($changed(twisterTuning) |-> $past(twSet) || $past(twSet, 2))
        else $error("twister tuning changed without cause");
    a_phy_source: assert property ($changed(phyTuningOne) |-> $past(phySet) || $past(phySet, 2))
        else $error("phy tuning changed without write");

    c_wake: cover property ($fell(pm_event_n));
    c_late_frame: cover property ($fell(frame_n) && gntDelayStrap);
    c_autoload: cover property (eeLoad.valid);
endmodule : cfgw_top_assertions

bind cfgw_top cfgw_top_assertions u_cfgw_top_assertions (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .gnt_n(gnt_n),
    .busReq(busReq), .gntDelayStrap(gntDelayStrap), .frame_n(frame_n), .rx(rx),
    .eeLoad(eeLoad), .phyTuningOne(phyTuningOne), .twisterTuning(twisterTuning),
    .pm_event_n(pm_event_n)
);

`default_nettype wire

// [cfgw_top_tb_top.sv]
// Self-checking bench for cfgw_top with the PCI arbiter model.
// Assumes the package, the design and the arbiter model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "cfgw_regs.svh"

module cfgw_top_tb_top;
    import cfgw_pkg::*;
    typedef struct {logic w; logic [31:0] d; logic e;} cfgw_exp_t;
    logic         clk, arst_n, psel, penable, pwrite, busReq, gntDelayStrap, gnt_n;
    logic         pready, pslverr, frame_n, pm_event_n, irq;
    logic [7:0]   paddr, phyTuningOne, phyTuningTwo, twisterTuning, v1, v2, v3, v4;
    logic [7:0]   nodeId [6];
    logic [31:0]  pwdata, prdata;
    logic [1:0]   grantLag;
    cfgw_rx_t     rx;
    cfgw_eeload_t eeLoad;
    cfgw_exp_t    expQ [$];
    cfgw_exp_t    nx;
    logic [7:0]   fq [$];
    int           errTotal, checkCount, n, m;
    int           cFf [8] = '{6, 7, 6, 6, 6, 5, 6, 6};
    int           cCp [8] = '{16, 16, 16, 16, 15, 16, 16, 16};
    bit [7:0]     cCrc = 8'hfb, cAm = 8'hf7, cAw = 8'h7f, cExp = 8'h43, cBrk = 8'h40;

    cfgw_top u_cfgw_top (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gnt_n(gnt_n), .busReq(busReq), .gntDelayStrap(gntDelayStrap),
        .frame_n(frame_n), .rx(rx), .eeLoad(eeLoad), .phyTuningOne(phyTuningOne),
        .phyTuningTwo(phyTuningTwo), .twisterTuning(twisterTuning),
        .pm_event_n(pm_event_n), .irq(irq)
    );
    cfgw_pci_arbiter u_cfgw_pci_arbiter (
        .clk(clk), .arst_n(arst_n), .busReq(busReq), .grantLag(grantLag), .gnt_n(gnt_n)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        checkCount++;
        if (got !== ex) begin
            errTotal++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic e = 1'b0);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        expQ.push_back('{w, d, e});
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Pairs each completed transfer with the oldest expectation
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            nx = expQ.pop_front();
            chk("pslverr", nx.e, pslverr);
            if (!nx.w) chk("prdata", nx.d, prdata);
        end
    end

    task automatic reset_dut(logic strap);
        arst_n <= 1'b0;
        gntDelayStrap <= strap;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : reset_dut

    task automatic grant_test();
        grantLag <= 2'($urandom_range(0, 3));
        @(posedge clk);
        busReq <= 1'b1;
        n = 0;
        m = 0;
        do begin
            @(posedge clk);
            n++;
            if (gnt_n === 1'b0 && frame_n === 1'b1) m++;
        end while (frame_n !== 1'b0 && n < 20);
        chk("frame_n low", 32'h0, frame_n);
        chk("grant to frame", 32'(gntDelayStrap) + 32'h1, m);
        repeat (3) @(posedge clk);
        busReq <= 1'b0;
        repeat (2) @(posedge clk);
        chk("frame_n high", 32'h1, frame_n);
        $display("test grant done");
    endtask : grant_test

    task automatic frame(int ff, int cp, bit brk, bit crc, bit am);
        fq.delete();
        repeat (12 + $urandom_range(0, 9)) fq.push_back(8'($urandom_range(0, 254)));
        if (brk) begin
            repeat (6) fq.push_back(8'hff);
            for (int i = 0; i < 3; i++) fq.push_back(nodeId[i]);
            fq.push_back(8'h00);
        end
        repeat (ff) fq.push_back(8'hff);
        repeat (cp) for (int i = 0; i < 6; i++) fq.push_back(nodeId[i]);
        repeat (4) fq.push_back(8'h5a);
        foreach (fq[i]) begin
            @(posedge clk);
            rx <= '{1'b1, i == 0, i == fq.size() - 1, crc, am, fq[i]};
        end
        @(posedge clk);
        rx <= '0;
    endtask : frame

    task automatic summarize();
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    initial begin
        #1000000;
        errTotal++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        {arst_n, psel, penable, pwrite, busReq, gntDelayStrap} = 6'h0;
        {paddr, pwdata, grantLag} = '0;
        rx = '0;
        eeLoad = '0;
        errTotal = 0;
        checkCount = 0;
        void'($urandom(83));
        reset_dut(1'b0);
        for (int a = 0; a <= 'h24; a += 4) apb(1'b0, 8'(a), 32'h0);
        apb(1'b0, 8'h28, 32'h0, 1'b1);
        apb(1'b1, 8'hfc, 32'hffff_ffff, 1'b1);
        $display("test reset done");
        v1 = 8'($urandom);
        v2 = 8'($urandom);
        v3 = 8'($urandom);
        v4 = 8'($urandom);
        apb(1'b1, `CFGW_OFF_EECMD, 32'h80);
        apb(1'b1, `CFGW_OFF_PHY1, {24'h0, v1});
        apb(1'b0, `CFGW_OFF_PHY1, 32'h0);
        apb(1'b1, `CFGW_OFF_EECMD, 32'hc0);
        apb(1'b1, `CFGW_OFF_PHY1, {24'h0, v1});
        apb(1'b1, `CFGW_OFF_PHY2, {24'h0, v2});
        apb(1'b1, `CFGW_OFF_TW, {24'h0, v3});
        apb(1'b0, `CFGW_OFF_PHY2, {24'h0, v2});
        apb(1'b0, `CFGW_OFF_TW, {24'h0, v3});
        chk("phyTuningOne", {24'h0, v1}, phyTuningOne);
        chk("phyTuningTwo", {24'h0, v2}, phyTuningTwo);
        apb(1'b1, `CFGW_OFF_CFG3, 32'hc0);
        apb(1'b0, `CFGW_OFF_CFG3, 32'h40);
        apb(1'b1, `CFGW_OFF_PHY1, {24'h0, ~v1});
        apb(1'b1, `CFGW_OFF_TW, {24'h0, ~v3});
        apb(1'b0, `CFGW_OFF_PHY1, {24'h0, v1});
        apb(1'b0, `CFGW_OFF_TW, {24'h0, v3});
        @(posedge clk);
        eeLoad <= '{1'b1, v4};
        @(posedge clk);
        eeLoad <= '0;
        apb(1'b0, `CFGW_OFF_TW, {24'h0, v4});
        apb(1'b0, `CFGW_OFF_PHY2, {24'h0, v2});
        chk("twisterTuning", {24'h0, v4}, twisterTuning);
        apb(1'b0, `CFGW_OFF_ISTAT, 32'h2);
        apb(1'b1, `CFGW_OFF_IMASK, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq masked in", 32'h1, irq);
        apb(1'b1, `CFGW_OFF_IMASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked out", 32'h0, irq);
        apb(1'b1, `CFGW_OFF_ISTAT, 32'h2);
        apb(1'b0, `CFGW_OFF_ISTAT, 32'h0);
        apb(1'b1, `CFGW_OFF_CFG3, 32'h0);
        $display("test tuning done");
        grant_test();
        reset_dut(1'b1);
        apb(1'b1, `CFGW_OFF_CFG3, 32'h0);
        apb(1'b0, `CFGW_OFF_CFG3, 32'h80);
        grant_test();
        foreach (nodeId[i]) nodeId[i] = 8'($urandom_range(0, 254));
        apb(1'b1, `CFGW_OFF_IDLO, {nodeId[3], nodeId[2], nodeId[1], nodeId[0]});
        apb(1'b1, `CFGW_OFF_IDHI, {16'h0, nodeId[5], nodeId[4]});
        apb(1'b1, `CFGW_OFF_CFG3, 32'h20);
        apb(1'b1, `CFGW_OFF_IMASK, 32'h1);
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, `CFGW_OFF_CFG1, {31'h0, cAw[k]});
            frame(cFf[k], cCp[k], cBrk[k], cCrc[k], cAm[k]);
            repeat (3) @(posedge clk);
            chk("pm_event_n", {31'h0, !cExp[k]}, pm_event_n);
            chk("irq wake", {31'h0, cExp[k]}, irq);
            apb(1'b1, `CFGW_OFF_ISTAT, 32'h1);
            repeat (2) @(posedge clk);
            chk("pm_event_n cleared", 32'h1, pm_event_n);
        end
        $display("test wake done");
        summarize();
    end
endmodule : cfgw_top_tb_top

`default_nettype wire
